// *** sim/pllsyn_core_properties.sv ***
// port assertions for the pll synthesizer core
`timescale 1ns/1ps
module pllsyn_core_props(input logic clk, rstn, tristate_phase_error_o,
	tristate_phase_error_oe, phase_vco_n, phase_ref_n, divided_vco_out,
	divided_reference, lock_indicator);
	wire oe = tristate_phase_error_oe;
	wire o = tristate_phase_error_o;
	wire vn = phase_vco_n;
	wire rn = phase_ref_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_neg_dir: assert property (oe && !o |-> !vn && rn) else $error("bad low");
	chk_pos_dir: assert property (oe && o |-> vn && !rn) else $error("bad high");
	chk_idle_float: assert property (vn == rn |-> !oe) else $error("bad drive");
	chk_both_brief: assert property (!vn && !rn |=> vn && rn) else $error("long pair");
	chk_lock_drop: assert property ((vn != rn) [*4] |-> ##[0:2] !lock_indicator)
		else $error("lock kept");
	chk_reset_vals: assert property ($rose(rstn) |-> vn && rn && !oe && lock_indicator
		&& !divided_vco_out && !divided_reference) else $error("bad reset");
	chk_vco_gap: assert property ($rose(divided_vco_out)
		|=> (!$rose(divided_vco_out)) [*2]) else $error("vco gap");
	chk_ref_gap: assert property ($rose(divided_reference)
		|=> (!$rose(divided_reference)) [*7]) else $error("ref gap");
	cover property (oe && !o);
	cover property (oe && o);
	cover property ($fell(lock_indicator));
endmodule
bind pllsyn_core pllsyn_core_props pllsyn_core_props_i(.*);

// *** sim/pllsyn_core_test.sv ***
// self-checking bench for the pll synthesizer core
`timescale 1ns/1ps
`define CK(x, y) begin cmp_count++; if ((x) !== (y)) begin error_cnt++; \
	$display("unexpected %0t value mismatch %0d %0d", $time, x, y); end end
module pllsyn_core_test;
	logic clk = 0, rstn = 0, tx_rx_select = 1, vco_in, reference_osc_in;
	logic o, oe, pv, pr, dvo, dr, lk;
	logic [2:0] ref_divide_select = 3'h0;
	logic [13:0] divide_value_inputs = 14'h0003;
	logic [31:0] seed = 32'hb3f5;
	int error_cnt = 0, cmp_count = 0, nv = 0, nr = 0, nl = 0, ng = 0, ps = 0;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		nv <= nv + (pv === 0 && pr === 1);
		nr <= nr + (pr === 0 && pv === 1);
		nl <= nl + (lk === 0);
		ng <= ng + (oe === 1 && o === 0);
		ps <= ps + (oe === 1 && o === 1);
	end
	pllsyn_osc_model pllsyn_osc_model_i(.vco_in, .reference_osc_in);
	pllsyn_core pllsyn_core_i(.clk, .rstn, .reference_osc_in, .vco_in, .ref_divide_select,
		.divide_value_inputs, .tx_rx_select, .tristate_phase_error_o(o),
		.tristate_phase_error_oe(oe), .phase_vco_n(pv), .phase_ref_n(pr),
		.divided_vco_out(dvo), .divided_reference(dr), .lock_indicator(lk));
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic int vspan(int n, bit t);
		return (n + (t ? 0 : 856)) * 4;
	endfunction
	function automatic int rspan(int s);
		int r[8] = '{8, 128, 256, 512, 1024, 2048, 2410, 8192};
		return r[s] * 2;
	endfunction
	// clk cycles between two divided pulses
	task automatic span(bit w, output int c);
		realtime t;
		repeat (8) @(posedge clk);
		if (w) @(posedge dr); else @(posedge dvo);
		t = $realtime;
		if (w) @(posedge dr); else @(posedge dvo);
		c = int'(($realtime - t) / 10);
		@(posedge clk);
	endtask
	task automatic test_done;
		if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#1000000;
		error_cnt++;
		test_done;
	end
	initial begin
		int a, b, l, c, x, y;
		repeat (6) @(posedge clk);
		rstn <= 1;
		// vco fast, then slow, against a 16-cycle reference
		for (int i = 0; i < 2; i++) begin
			divide_value_inputs <= i ? 14'h0005 : 14'h0003;
			span(0, c);
			`CK(c, vspan(i ? 5 : 3, 1))
			a = nv;
			b = nr;
			l = nl;
			x = ng;
			y = ps;
			repeat (300) @(posedge clk);
			`CK((nv - a > nr - b) ^ i, 1)
			`CK((ng - x > ps - y) ^ i, 1)
			`CK(nl > l, 1)
		end
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			divide_value_inputs <= 14'(3 + seed[7:0]);
			tx_rx_select <= i[0];
			span(0, c);
			`CK(c, vspan(3 + seed[7:0], i[0]))
		end
		for (int s = 0; s < 8; s++) begin
			ref_divide_select <= 3'(s);
			span(1, c);
			`CK(c, rspan(s))
		end
		test_done;
	end
endmodule

// *** sim/pllsyn_osc_model.sv ***
// vco and reference oscillators of the loop
`timescale 1ns/1ps
module pllsyn_osc_model(output logic vco_in, output logic reference_osc_in);
	initial vco_in = 1'b0;
	initial reference_osc_in = 1'b0;
	always #20 vco_in = ~vco_in;
	always #10 reference_osc_in = ~reference_osc_in;
endmodule

// *** verilog/pllsyn_core.sv ***
// parallel pll synthesizer digital core
`timescale 1ns/1ps
module pllsyn_core
	import pllsyn_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// reference oscillator and vco inputs
	input wire logic reference_osc_in,
	input wire logic vco_in,
	// parallel programming
	input wire logic [2:0] ref_divide_select,
	input wire logic [13:0] divide_value_inputs,
	input wire logic tx_rx_select,
	// phase detector outputs
	output logic tristate_phase_error_o,
	output logic tristate_phase_error_oe,
	output logic phase_vco_n,
	output logic phase_ref_n,
	// divided signals and lock
	output logic divided_vco_out,
	output logic divided_reference,
	output logic lock_indicator
);
	pllsyn_ndiv_if nd();
	logic [R_WIDTH-1:0] ref_count;
	logic [R_WIDTH-1:0] ref_ratio;
	logic ref_pulse;
	logic vco_sync1;
	logic vco_sync2;
	logic vco_last;
	logic vco_rise;
	logic up;
	logic down;
	logic [1:0] lock_count;

	// r counter runs on the reference oscillator
	assign vco_rise = vco_sync2 && !vco_last;

	always_comb begin
		unique case (ref_divide_select)
			3'h0: ref_ratio = R_DIV_0;
			3'h1: ref_ratio = R_DIV_1;
			3'h2: ref_ratio = R_DIV_2;
			3'h3: ref_ratio = R_DIV_3;
			3'h4: ref_ratio = R_DIV_4;
			3'h5: ref_ratio = R_DIV_5;
			3'h6: ref_ratio = R_DIV_6;
			3'h7: ref_ratio = R_DIV_7;
		endcase
	end

	always_ff @(posedge reference_osc_in or negedge rstn) begin
		if (!rstn) begin
			ref_count <= 14'h0000;
		end else if (ref_count >= ref_ratio - 14'h0001) begin
			ref_count <= 14'h0000;
		end else begin
			ref_count <= ref_count + 14'h0001;
		end
	end

	always_ff @(posedge reference_osc_in or negedge rstn) begin
		if (!rstn) begin
			ref_pulse <= 1'b0;
		end else begin
			ref_pulse <= (ref_count >= ref_ratio - 14'h0001);
		end
	end

	// n counter load value, offset applied when transmit/receive low
	always_comb begin
		nd.load_value = {1'b0, divide_value_inputs};
		if (!tx_rx_select) begin
			nd.load_value = {1'b0, divide_value_inputs} + TR_OFFSET;
		end
	end

	pllsyn_ndiv u_ndiv (
		.vco_in(vco_in),
		.rstn(rstn),
		.nd(nd)
	);

	// bring the divided signals into clk
	logic ref_sync1;
	logic ref_sync2;
	logic ref_last;
	logic ref_rise;
	assign ref_rise = ref_sync2 && !ref_last;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vco_sync1 <= 1'b0;
			vco_sync2 <= 1'b0;
			vco_last <= 1'b0;
			ref_sync1 <= 1'b0;
			ref_sync2 <= 1'b0;
			ref_last <= 1'b0;
		end else begin
			vco_sync1 <= nd.divided_pulse;
			vco_sync2 <= vco_sync1;
			vco_last <= vco_sync2;
			ref_sync1 <= ref_pulse;
			ref_sync2 <= ref_sync1;
			ref_last <= ref_sync2;
		end
	end

	// phase frequency detector: up means vco slow, down means vco fast
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			up <= 1'b0;
			down <= 1'b0;
		end else if ((up || ref_rise) && (down || vco_rise)) begin
			up <= 1'b0;
			down <= 1'b0;
		end else begin
			up <= up || ref_rise;
			down <= down || vco_rise;
		end
	end

	// coincident edges give a one-cycle pulse on both outputs
	logic both_pulse;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			both_pulse <= 1'b0;
		end else begin
			both_pulse <= ref_rise && vco_rise && !up && !down;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_vco_n <= 1'b1;
			phase_ref_n <= 1'b1;
			tristate_phase_error_o <= 1'b0;
			tristate_phase_error_oe <= 1'b0;
		end else begin
			phase_vco_n <= !(down || both_pulse);
			phase_ref_n <= !(up || both_pulse);
			tristate_phase_error_o <= up && !down;
			tristate_phase_error_oe <= up ^ down;
		end
	end

	// buffered divided outputs
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			divided_vco_out <= 1'b0;
			divided_reference <= 1'b0;
		end else begin
			divided_vco_out <= vco_sync2;
			divided_reference <= ref_sync2;
		end
	end

	// lock indicator low while either error is pending beyond a short window
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock_count <= 2'h0;
		end else if (up ^ down) begin
			if (lock_count != 2'(LOCK_HOLD)) begin
				lock_count <= lock_count + 2'h1;
			end
		end else begin
			lock_count <= 2'h0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock_indicator <= 1'b1;
		end else begin
			lock_indicator <= !((up ^ down) && lock_count == 2'(LOCK_HOLD));
		end
	end
endmodule

// *** verilog/pllsyn_ndiv.sv ***
// programmable divide-by-n counter on the vco input clock
`timescale 1ns/1ps
module pllsyn_ndiv
	import pllsyn_pkg::*;
(
	// clock and reset
	input wire logic vco_in,
	input wire logic rstn,
	// core side
	pllsyn_ndiv_if.ctr nd
);
	logic [N_WIDTH:0] count;

	always_ff @(posedge vco_in or negedge rstn) begin
		if (!rstn) begin
			count <= 15'h0000;
		end else if (count == 15'h0000) begin
			count <= nd.load_value - 15'h0001;
		end else begin
			count <= count - 15'h0001;
		end
	end

	always_ff @(posedge vco_in or negedge rstn) begin
		if (!rstn) begin
			nd.divided_pulse <= 1'b0;
		end else begin
			nd.divided_pulse <= (count == 15'h0000);
		end
	end
endmodule

// *** verilog/pllsyn_ndiv_if.sv ***
// divide-by-n counter connection: program value in, divided pulse out
`timescale 1ns/1ps
interface pllsyn_ndiv_if;
	logic [14:0] load_value;
	logic divided_pulse;
	modport core (output load_value, input divided_pulse);
	modport ctr (input load_value, output divided_pulse);
endinterface

// *** verilog/pllsyn_pkg.sv ***
// constants for the parallel pll synthesizer core
package pllsyn_pkg;
	localparam int N_WIDTH = 14;
	localparam int R_WIDTH = 14;
	localparam int SEL_WIDTH = 3;
	localparam logic [N_WIDTH-1:0] N_MIN = 14'h0003;
	localparam logic [N_WIDTH-1:0] N_MAX = 14'h3fff;
	localparam logic [N_WIDTH:0] TR_OFFSET = 15'h0358;
	localparam logic [R_WIDTH-1:0] R_DIV_0 = 14'h0008;
	localparam logic [R_WIDTH-1:0] R_DIV_1 = 14'h0080;
	localparam logic [R_WIDTH-1:0] R_DIV_2 = 14'h0100;
	localparam logic [R_WIDTH-1:0] R_DIV_3 = 14'h0200;
	localparam logic [R_WIDTH-1:0] R_DIV_4 = 14'h0400;
	localparam logic [R_WIDTH-1:0] R_DIV_5 = 14'h0800;
	localparam logic [R_WIDTH-1:0] R_DIV_6 = 14'h096a;
	localparam logic [R_WIDTH-1:0] R_DIV_7 = 14'h2000;
	localparam int LOCK_HOLD = 2;
endpackage
